// File: tcct_consts.vh
// Register map, field positions and reset values of the capture/compare timer
`ifndef TCCT_CONSTS_VH
`define TCCT_CONSTS_VH
`define TCCT_OFS_CTRL 8'h00
`define TCCT_OFS_CNT 8'h04
`define TCCT_OFS_MOD 8'h08
`define TCCT_OFS_CH0C 8'h0C
`define TCCT_OFS_CH0V 8'h10
`define TCCT_OFS_CH1C 8'h14
`define TCCT_OFS_CH1V 8'h18
`define TCCT_ADDR_HI_ZERO 24'h00_0000
`define TCCT_TC_FLAG 7
`define TCCT_TC_IE 6
`define TCCT_TC_STOP 5
`define TCCT_TC_RST 4
`define TCCT_TC_PS_HI 2
`define TCCT_TC_PS_LO 0
`define TCCT_CC_FLAG 7
`define TCCT_CC_IE 6
`define TCCT_CC_LINK 5
`define TCCT_CC_MODE 4
`define TCCT_CC_ELS_HI 3
`define TCCT_CC_ELS_LO 2
`define TCCT_CC_TOV 1
`define TCCT_CC_MAX 0
`define TCCT_MOD_RST 16'hFFFF
`define TCCT_CNT_RST 16'h0000
`define TCCT_STOP_RST 1'b1
`define TCCT_PS_RST 3'h0
`define TCCT_PS_EXT 3'h7
`define TCCT_ELS_OFF 2'h0
`define TCCT_ELS_TOG 2'h1
`define TCCT_ELS_CLR 2'h2
`define TCCT_ELS_SET 2'h3
`define TCCT_RD_ZERO 32'h0000_0000
`endif

// File: tcct_presc.v
// Counter clock prescaler: seven bus clock rates or the external timer clock
`timescale 1ns/10ps
`default_nettype none
`include "tcct_consts.vh"
module tcct_presc #(
  parameter DW = 6
) (
  input wire hclk,
  input wire hresetn,
  input wire clr,
  input wire [2:0] clock_divider_select,
  input wire ext_s,
  output reg tick
);
  reg [DW-1:0] div;
  reg ext_d;
  wire [DW:0] sh = {{DW{1'b0}}, 1'b1} << clock_divider_select;
  wire [DW:0] mk = sh - {{DW{1'b0}}, 1'b1};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div <= {DW{1'b0}};
      ext_d <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      ext_d <= ext_s;
      if (clr)
      begin
        div <= {DW{1'b0}};
        tick <= 1'b0;
      end
      else
      begin
        div <= div + {{(DW-1){1'b0}}, 1'b1};
        // Rising edge of the pin counts when the external source is picked
        if (clock_divider_select == `TCCT_PS_EXT)
          tick <= ext_s & ~ext_d;
        else
          tick <= ((div & mk[DW-1:0]) == mk[DW-1:0]);
      end
    end
  end
endmodule
`default_nettype wire

// File: tcct_chan.v
// One capture/compare channel: edge detect, compare match and pin action
`timescale 1ns/10ps
`default_nettype none
`include "tcct_consts.vh"
module tcct_chan #(
  parameter CW = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire cmp_mode,
  input wire [1:0] els,
  input wire toggle_on_rollover,
  input wire channel_max_duty,
  input wire upd,
  input wire ovf,
  input wire [CW-1:0] cnt,
  input wire [CW-1:0] cmp_val,
  input wire pin_s,
  output reg hit,
  output reg pin_out
);
  reg pin_d;
  reg next_pin;
  wire rise = pin_s & ~pin_d;
  wire fall = ~pin_s & pin_d;
  wire match = upd & (cnt == cmp_val);

  always @*
  begin
    next_pin = pin_out;
    if (ovf && toggle_on_rollover)
      next_pin = ~next_pin;
    if (match)
    begin
      case (els)
        `TCCT_ELS_TOG: next_pin = ~pin_out;
        `TCCT_ELS_CLR: next_pin = 1'b0;
        `TCCT_ELS_SET: next_pin = 1'b1;
        default: next_pin = next_pin;
      endcase
    end
    if (channel_max_duty && toggle_on_rollover)
      next_pin = ~els[0];
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_d <= 1'b0;
      hit <= 1'b0;
      pin_out <= 1'b0;
    end
    else
    begin
      pin_d <= pin_s;
      if (cmp_mode)
      begin
        hit <= match;
        pin_out <= next_pin;
      end
      else
      begin
        hit <= (els[0] & rise) | (els[1] & fall);
        pin_out <= pin_out;
      end
    end
  end
endmodule
`default_nettype wire

// File: tcct_top.v
// Two-channel capture/compare timer with AHB-Lite register access
// Functional notes
// - One 16-bit up-counter, free running or limited by the modulo value.
// - Counter reads return the live count and never disturb counting.
// - Each channel is set independently to input capture or output compare.
// - Three-bit divider select picks seven bus clock rates or external clock.
// - Active capture edge copies the count into that channel's value register.
// - Capture events can request an interrupt when the channel enable is set.
// - On compare match the pin is set, cleared or toggled as configured.
// - Compare matches can request an interrupt when the channel enable is set.
// - Unbuffered value writes act at once; a passed value skips that period.
// - Compare event ends the pulse; overflow event ends the period.
// - Link bit in channel 0 pairs channels onto pin 0, channel 0 first.
// - Linked: after each overflow the last written value register takes over.
// - Linked: channel 0 control governs, channel 1 idle, its pin released.
// - Toggle on rollover flips the pin when the count rolls over from modulo to zero, except while max duty holds the pin.
// - With high edge select set, low edge select 0 clears pin on compare, 1 sets it.
// - Period is modulo plus one counter clocks, 256 counter clocks for $00FF.
// - A stop bit halts counting and a reset bit clears the counter.
// - Overflow flag sets when the count rolls from modulo to zero; enable raises overflow request.
// - Channel flag sets on each capture or compare; enable raises request.
// - Max duty with toggle on rollover gives a 100 percent duty output.
`timescale 1ns/10ps
`default_nettype none
`include "tcct_consts.vh"
module tcct_top #(
  parameter CW = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  input wire external_timer_clock_pin,
  input wire channel_zero_pin_in,
  output wire channel_zero_pin_out,
  output reg channel_zero_pin_oe,
  input wire channel_one_pin_in,
  output wire channel_one_pin_out,
  output reg channel_one_pin_oe,
  output reg overflow_irq,
  output reg channel_zero_irq,
  output reg channel_one_irq
);
  // Pin synchronisers: first stage feeds only the second
  reg [2:0] pin_a;
  reg [2:0] pin_b;
  // Bus data phase state
  reg ap_wr;
  reg [7:0] ap_addr;
  reg [31:0] rd;
  // Timer control
  reg overflow_flag;
  reg overflow_irq_enable;
  reg stop;
  reg [2:0] clock_divider_select;
  reg [CW-1:0] modulo_value_regs;
  reg [CW-1:0] counter_value_regs;
  reg upd;
  reg ovf;
  // Channel control, index 0 and 1
  reg [1:0] channel_event_flag;
  reg [1:0] channel_irq_enable;
  reg [1:0] cmp_mode;
  reg [1:0] els0;
  reg [1:0] els1;
  reg [1:0] toggle_on_rollover;
  reg [1:0] channel_max_duty;
  reg pair_link_select;
  reg [CW-1:0] val0;
  reg [CW-1:0] val1;
  reg act_sel;
  reg last_wr;
  wire tick;
  wire [1:0] hit;
  wire take = hsel & hready & htrans[1];
  wire hi_ok = (haddr[31:8] == `TCCT_ADDR_HI_ZERO);
  wire wr_ctrl = ap_wr & (ap_addr == `TCCT_OFS_CTRL);
  wire wr_mod = ap_wr & (ap_addr == `TCCT_OFS_MOD);
  wire wr_c0 = ap_wr & (ap_addr == `TCCT_OFS_CH0C);
  wire wr_v0 = ap_wr & (ap_addr == `TCCT_OFS_CH0V);
  wire wr_c1 = ap_wr & (ap_addr == `TCCT_OFS_CH1C);
  wire wr_v1 = ap_wr & (ap_addr == `TCCT_OFS_CH1V);
  wire trst = wr_ctrl & hwdata[`TCCT_TC_RST];
  wire run = tick & ~stop;
  wire at_mod = (counter_value_regs == modulo_value_regs);
  // Linked pair forces compare on channel 0, silences channel 1
  wire mode0_eff = cmp_mode[0] | pair_link_select;
  wire mode1_eff = cmp_mode[1] & ~pair_link_select;
  wire [1:0] els1_eff = pair_link_select ? `TCCT_ELS_OFF : els1;
  wire [1:0] cap = hit & ~{mode1_eff, mode0_eff};
  wire ev1 = hit[1] & ~pair_link_select;
  // Active value of the linked pair
  wire [CW-1:0] cmp0 = (pair_link_select && act_sel) ? val1 : val0;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_a <= 3'h0;
      pin_b <= 3'h0;
    end
    else
    begin
      pin_a <= {external_timer_clock_pin, channel_one_pin_in, channel_zero_pin_in};
      pin_b <= pin_a;
    end
  end

  tcct_presc u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(trst),
    .clock_divider_select(clock_divider_select),
    .ext_s(pin_b[2]),
    .tick(tick)
  );

  tcct_chan #(.CW(CW)) u_ch0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .cmp_mode(mode0_eff),
    .els(els0),
    .toggle_on_rollover(toggle_on_rollover[0]),
    .channel_max_duty(channel_max_duty[0]),
    .upd(upd),
    .ovf(ovf),
    .cnt(counter_value_regs),
    .cmp_val(cmp0),
    .pin_s(pin_b[0]),
    .hit(hit[0]),
    .pin_out(channel_zero_pin_out)
  );

  tcct_chan #(.CW(CW)) u_ch1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .cmp_mode(mode1_eff),
    .els(els1_eff),
    .toggle_on_rollover(toggle_on_rollover[1] & ~pair_link_select),
    .channel_max_duty(channel_max_duty[1] & ~pair_link_select),
    .upd(upd),
    .ovf(ovf),
    .cnt(counter_value_regs),
    .cmp_val(val1),
    .pin_s(pin_b[1]),
    .hit(hit[1]),
    .pin_out(channel_one_pin_out)
  );

  // Counter, modulo plus one ticks a period
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      counter_value_regs <= `TCCT_CNT_RST;
      upd <= 1'b0;
      ovf <= 1'b0;
    end
    else
    begin
      upd <= run & ~trst;
      ovf <= run & ~trst & at_mod;
      if (trst)
        counter_value_regs <= `TCCT_CNT_RST;
      else if (run)
      begin
        if (at_mod)
          counter_value_regs <= `TCCT_CNT_RST;
        else
          counter_value_regs <= counter_value_regs + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Timer control and overflow flag
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
      stop <= `TCCT_STOP_RST;
      clock_divider_select <= `TCCT_PS_RST;
      modulo_value_regs <= `TCCT_MOD_RST;
    end
    else
    begin
      if (ovf)
        overflow_flag <= 1'b1;
      else if (wr_ctrl && !hwdata[`TCCT_TC_FLAG])
        overflow_flag <= 1'b0;
      if (wr_ctrl)
      begin
        overflow_irq_enable <= hwdata[`TCCT_TC_IE];
        stop <= hwdata[`TCCT_TC_STOP];
        clock_divider_select <= hwdata[`TCCT_TC_PS_HI:`TCCT_TC_PS_LO];
      end
      if (wr_mod)
        modulo_value_regs <= hwdata[CW-1:0];
    end
  end

  // Channel control words
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      channel_event_flag <= 2'h0;
      channel_irq_enable <= 2'h0;
      cmp_mode <= 2'h0;
      els0 <= `TCCT_ELS_OFF;
      els1 <= `TCCT_ELS_OFF;
      toggle_on_rollover <= 2'h0;
      channel_max_duty <= 2'h0;
      pair_link_select <= 1'b0;
    end
    else
    begin
      // Channel flag, set wins over clear
      if (hit[0])
        channel_event_flag[0] <= 1'b1;
      else if (wr_c0 && !hwdata[`TCCT_CC_FLAG])
        channel_event_flag[0] <= 1'b0;
      if (ev1)
        channel_event_flag[1] <= 1'b1;
      else if (wr_c1 && !hwdata[`TCCT_CC_FLAG])
        channel_event_flag[1] <= 1'b0;
      if (wr_c0)
      begin
        channel_irq_enable[0] <= hwdata[`TCCT_CC_IE];
        pair_link_select <= hwdata[`TCCT_CC_LINK];
        cmp_mode[0] <= hwdata[`TCCT_CC_MODE];
        els0 <= hwdata[`TCCT_CC_ELS_HI:`TCCT_CC_ELS_LO];
        toggle_on_rollover[0] <= hwdata[`TCCT_CC_TOV];
        channel_max_duty[0] <= hwdata[`TCCT_CC_MAX];
      end
      if (wr_c1)
      begin
        channel_irq_enable[1] <= hwdata[`TCCT_CC_IE];
        cmp_mode[1] <= hwdata[`TCCT_CC_MODE];
        els1 <= hwdata[`TCCT_CC_ELS_HI:`TCCT_CC_ELS_LO];
        toggle_on_rollover[1] <= hwdata[`TCCT_CC_TOV];
        channel_max_duty[1] <= hwdata[`TCCT_CC_MAX];
      end
    end
  end

  // Channel value registers and buffered pair selection
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      val0 <= `TCCT_CNT_RST;
      val1 <= `TCCT_CNT_RST;
      act_sel <= 1'b0;
      last_wr <= 1'b0;
    end
    else
    begin
      if (cap[0])
        val0 <= counter_value_regs;
      else if (wr_v0)
        val0 <= hwdata[CW-1:0];
      if (cap[1])
        val1 <= counter_value_regs;
      else if (wr_v1)
        val1 <= hwdata[CW-1:0];
      // Channel 0 leads when link is first set
      if (wr_c0 && hwdata[`TCCT_CC_LINK] && !pair_link_select)
      begin
        act_sel <= 1'b0;
        last_wr <= 1'b0;
      end
      else
      begin
        if (wr_v1)
          last_wr <= 1'b1;
        else if (wr_v0)
          last_wr <= 1'b0;
        if (!pair_link_select)
          act_sel <= 1'b0;
        else if (ovf)
          act_sel <= wr_v1 | (last_wr & ~wr_v0);
      end
    end
  end

  // Pin drive enables and interrupt requests
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      channel_zero_pin_oe <= 1'b0;
      channel_one_pin_oe <= 1'b0;
      overflow_irq <= 1'b0;
      channel_zero_irq <= 1'b0;
      channel_one_irq <= 1'b0;
    end
    else
    begin
      channel_zero_pin_oe <= mode0_eff & (els0 != `TCCT_ELS_OFF);
      channel_one_pin_oe <= mode1_eff & (els1 != `TCCT_ELS_OFF);
      overflow_irq <= overflow_flag & overflow_irq_enable;
      channel_zero_irq <= channel_event_flag[0] & channel_irq_enable[0];
      channel_one_irq <= channel_event_flag[1] & channel_irq_enable[1];
    end
  end

  // Read mux, decoded in the address phase
  always @*
  begin
    rd = `TCCT_RD_ZERO;
    if (!hi_ok)
      rd = `TCCT_RD_ZERO;
    else if (haddr[7:0] == `TCCT_OFS_CTRL)
    begin
      rd[`TCCT_TC_FLAG] = overflow_flag;
      rd[`TCCT_TC_IE] = overflow_irq_enable;
      rd[`TCCT_TC_STOP] = stop;
      rd[`TCCT_TC_PS_HI:`TCCT_TC_PS_LO] = clock_divider_select;
    end
    else if (haddr[7:0] == `TCCT_OFS_CNT)
      rd[CW-1:0] = counter_value_regs;
    else if (haddr[7:0] == `TCCT_OFS_MOD)
      rd[CW-1:0] = modulo_value_regs;
    else if (haddr[7:0] == `TCCT_OFS_CH0C)
      rd[7:0] = {channel_event_flag[0], channel_irq_enable[0], pair_link_select,
                 cmp_mode[0], els0, toggle_on_rollover[0], channel_max_duty[0]};
    else if (haddr[7:0] == `TCCT_OFS_CH0V)
      rd[CW-1:0] = val0;
    else if (haddr[7:0] == `TCCT_OFS_CH1C)
      rd[7:0] = {channel_event_flag[1], channel_irq_enable[1], 1'b0,
                 cmp_mode[1], els1, toggle_on_rollover[1], channel_max_duty[1]};
    else if (haddr[7:0] == `TCCT_OFS_CH1V)
      rd[CW-1:0] = val1;
  end

  // Zero wait state slave; hsize is ignored, every access is a whole word
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
      hrdata <= `TCCT_RD_ZERO;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ap_wr <= take & hwrite & hi_ok;
      if (take)
        ap_addr <= haddr[7:0];
      if (take && !hwrite)
        hrdata <= rd;
      else
        hrdata <= `TCCT_RD_ZERO;
    end
  end
endmodule
`default_nettype wire

// File: tcct_monitor.sv
// Port-level assertions of the capture/compare timer
`timescale 1ns/10ps
`default_nettype none
`include "tcct_consts.vh"
module tcct_monitor (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp,
  input wire channel_one_pin_oe,
  input wire overflow_irq,
  input wire channel_one_irq
);
  wire take = hsel && hready && htrans[1];
  wire rd = take && !hwrite;
  reg wp;
  reg [7:0] wa;
  reg ie_t;
  reg lk0;
  reg [7:0] c1;
  // Mirrors control bits with the register write timing
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wp <= 1'b0;
      wa <= 8'h00;
      ie_t <= 1'b0;
      lk0 <= 1'b0;
      c1 <= 8'h00;
    end
    else
    begin
      wp <= take && hwrite && haddr[31:8] == `TCCT_ADDR_HI_ZERO;
      wa <= haddr[7:0];
      if (wp && wa == `TCCT_OFS_CTRL)
        ie_t <= hwdata[`TCCT_TC_IE];
      if (wp && wa == `TCCT_OFS_CH0C)
        lk0 <= hwdata[`TCCT_CC_LINK];
      if (wp && wa == `TCCT_OFS_CH1C)
        c1 <= hwdata[7:0];
    end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence rd_s;
    rd;
  endsequence
  sequence rd_far_s;
    rd && haddr[31:8] != `TCCT_ADDR_HI_ZERO;
  endsequence
  ready_high_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  idle_data_a: assert property (!rd |=> hrdata == `TCCT_RD_ZERO)
    else $error("hrdata not zero outside read");
  unmapped_zero_a: assert property (rd_far_s |=> hrdata == `TCCT_RD_ZERO)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (rd_s |=> hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  link_read_a: assert property (rd_s ##0
    haddr == {`TCCT_ADDR_HI_ZERO, `TCCT_OFS_CH1C} |=> !hrdata[`TCCT_CC_LINK])
    else $error("link bit of channel one reads set");
  one_oe_a: assert property (channel_one_pin_oe ==
    $past(c1[`TCCT_CC_MODE] && c1[3:2] != `TCCT_ELS_OFF && !lk0))
    else $error("channel one enable wrong");
  ovf_irq_a: assert property ($past(!ie_t) |-> !overflow_irq)
    else $error("overflow request while disabled");
  ch1_irq_a: assert property ($past(!c1[`TCCT_CC_IE]) |-> !channel_one_irq)
    else $error("channel one request while disabled");
endmodule
`default_nettype wire

// File: tcct_pin_model.sv
// Far-side sources on the two channel pins
`timescale 1ns/10ps
`default_nettype none
module tcct_pin_model (
  input wire drv0,
  input wire drv1,
  input wire out0,
  input wire oe0,
  input wire out1,
  input wire oe1,
  output wire lvl0,
  output wire lvl1
);
  // Enabled timer output owns the wire, else the external source
  assign lvl0 = oe0 ? out0 : drv0;
  assign lvl1 = oe1 ? out1 : drv1;
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench of the capture/compare timer
`timescale 1ns/10ps
`default_nettype none
`include "tcct_consts.vh"
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic ext_clk = 1'b0;
  logic drv0 = 1'b0;
  logic drv1 = 1'b0;
  logic [23:0] hi = 24'h00_0000;
  logic [31:0] a;
  logic [31:0] b;
  wire hreadyout, hresp, pin0, pin1, out0, oe0, out1, oe1, ovf_irq, irq0, irq1;
  wire [31:0] hrdata;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int k;
  time t0;
  always #50 hclk = ~hclk;
  tcct_top #(.CW(16)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .external_timer_clock_pin(ext_clk), .channel_zero_pin_in(pin0),
    .channel_zero_pin_out(out0), .channel_zero_pin_oe(oe0), .channel_one_pin_in(pin1),
    .channel_one_pin_out(out1), .channel_one_pin_oe(oe1), .overflow_irq(ovf_irq),
    .channel_zero_irq(irq0), .channel_one_irq(irq1));
  tcct_pin_model pins_u (.drv0(drv0), .drv1(drv1), .out0(out0), .oe0(oe0),
    .out1(out1), .oe1(oe1), .lvl0(pin0), .lvl1(pin1));
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Entered just after a rising edge; one single word transfer
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d,
    output logic [31:0] q);
    haddr <= {hi, ad};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, ad, d, q);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, ad, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  task automatic cnt(output logic [31:0] q);
    xfer(1'b0, `TCCT_OFS_CNT, 32'h0000_0000, q);
  endtask
  task automatic wait_sig(input logic s, input logic v);
    int n;
    n = 0;
    while ((s ? ovf_irq : pin0) !== v && n < 3000)
    begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic pwm(input logic p, input logic [31:0] wid);
    time ts;
    wait_sig(1'b0, ~p);
    wait_sig(1'b0, p);
    ts = $time;
    wait_sig(1'b0, ~p);
    chk(32'(($time - ts) / 100), wid);
    wait_sig(1'b0, p);
    chk(32'(($time - ts) / 100), 32'h0000_0100);
  endtask
  // Counter runs briefly so each capture sees a fresh count
  task automatic cap(input logic [7:0] cfg, input logic lvl, input logic capt);
    logic [31:0] c;
    logic [31:0] old;
    wr(`TCCT_OFS_CH1C, {24'h00_0000, cfg});
    wr(`TCCT_OFS_CTRL, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    wr(`TCCT_OFS_CTRL, 32'h0000_0020);
    cnt(c);
    xfer(1'b0, `TCCT_OFS_CH1V, 32'h0000_0000, old);
    drv1 <= lvl;
    repeat (8) @(posedge hclk);
    rdc(`TCCT_OFS_CH1V, capt ? c : old);
    chk(32'(irq1), 32'(capt));
  endtask
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    rdc(`TCCT_OFS_CTRL, 32'h0000_0020);
    rdc(`TCCT_OFS_MOD, 32'h0000_FFFF);
    rdc(`TCCT_OFS_CNT, 32'h0000_0000);
    rdc(`TCCT_OFS_CH1C, 32'h0000_0000);
    rdc(8'h1C, 32'h0000_0000);
    hi = 24'h00_0001;
    rdc(`TCCT_OFS_MOD, 32'h0000_0000);
    hi = 24'h00_0000;
    // Waits of 4 ticks minus the two cycles a read spends
    for (int n = 0; n < 7; n++)
    begin
      wr(`TCCT_OFS_CTRL, 32'(n));
      // Tick already in flight still follows the old divider
      @(posedge hclk);
      cnt(a);
      repeat ((4 << n) - 2) @(posedge hclk);
      cnt(b);
      chk((b - a) & 32'h0000_FFFF, 32'h0000_0004);
    end
    wr(`TCCT_OFS_CTRL, 32'h0000_0007);
    @(posedge hclk);
    cnt(a);
    repeat (3)
    begin
      ext_clk <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    cnt(b);
    chk((b - a) & 32'h0000_FFFF, 32'h0000_0003);
    wr(`TCCT_OFS_CTRL, 32'h0000_0020);
    cnt(a);
    repeat (9) @(posedge hclk);
    cnt(b);
    chk(b, a);
    wr(`TCCT_OFS_CTRL, 32'h0000_0030);
    rdc(`TCCT_OFS_CNT, 32'h0000_0000);
    rdc(`TCCT_OFS_CTRL, 32'h0000_0020);
    wr(`TCCT_OFS_MOD, 32'h0000_00FF);
    wr(`TCCT_OFS_CTRL, 32'h0000_0040);
    wait_sig(1'b1, 1'b1);
    t0 = $time;
    rdc(`TCCT_OFS_CTRL, 32'h0000_00C0);
    wr(`TCCT_OFS_CTRL, 32'h0000_0040);
    wait_sig(1'b1, 1'b0);
    wait_sig(1'b1, 1'b1);
    chk(32'(($time - t0) / 100), 32'h0000_0100);
    wr(`TCCT_OFS_CH0V, 32'h0000_0080);
    wr(`TCCT_OFS_CH0C, 32'h0000_005A);
    pwm(1'b1, 32'h0000_0080);
    chk(32'(oe0), 32'h0000_0001);
    rdc(`TCCT_OFS_CH0C, 32'h0000_00DA);
    chk(32'(irq0), 32'h0000_0001);
    // Smaller value written at the compare, larger one at the overflow
    wait_sig(1'b0, 1'b0);
    wr(`TCCT_OFS_CH0V, 32'h0000_0040);
    pwm(1'b1, 32'h0000_0040);
    wr(`TCCT_OFS_CH0V, 32'h0000_0080);
    wr(`TCCT_OFS_CH0C, 32'h0000_005E);
    pwm(1'b0, 32'h0000_0080);
    wr(`TCCT_OFS_CH0C, 32'h0000_005B);
    repeat (4) @(posedge hclk);
    k = 0;
    repeat (300)
    begin
      @(posedge hclk);
      k += (pin0 !== 1'b1);
    end
    chk(32'(k), 32'h0000_0000);
    wr(`TCCT_OFS_CH1C, 32'h0000_0038);
    rdc(`TCCT_OFS_CH1C, 32'h0000_0018);
    wr(`TCCT_OFS_CH0C, 32'h0000_002A);
    wr(`TCCT_OFS_CH1V, 32'h0000_00C0);
    chk(32'(oe1), 32'h0000_0000);
    pwm(1'b1, 32'h0000_00C0);
    wr(`TCCT_OFS_CH0V, 32'h0000_0020);
    pwm(1'b1, 32'h0000_0020);
    wr(`TCCT_OFS_CH0C, 32'h0000_0000);
    for (int i = 0; i < 6; i++)
      cap(8'h44 + 8'(4 * (i / 2)), ~i[0], i != 1 && i != 2);
    end_sim();
  end
endmodule
bind tcct_top tcct_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .channel_one_pin_oe(channel_one_pin_oe), .overflow_irq(overflow_irq),
  .channel_one_irq(channel_one_irq));
`default_nettype wire
